// File: verilog/adc_timing_params.svh
`ifndef ADC_TIMING_PARAMS_SVH
`define ADC_TIMING_PARAMS_SVH
// Contract
// - 40MHz samples every edge, 80MHz alternate edges.
// - internal conversion always runs at 40MHz.
// - dual bus latency 8 or 4 cycles.
// - single bus latency A 8, B 9.
// - standby high powers the device down.
// - reference powerdown disables reference, conversion continues.
// - output enable low drives, high floats outputs.
// - mode and single bus bits choose option.
// - secondary bus only in dual mode.
// - mode and format bits apply without resync.
// - format bit selects unsigned or signed_format_select complement.

// apb register byte offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
// control field positions
`define CTRL_CLOCK_MODE_BIT 0
`define CTRL_SINGLE_BUS_BIT 1
`define CTRL_SIGNED_BIT 2
`define CTRL_STANDBY_BIT 3
`define CTRL_REF_PDWN_BIT 4
`define CTRL_OUT_ENABLE_N_BIT 5
`define CTRL_RESET_VALUE 6'h20
// pipeline latencies in input clock cycles
`define LAT_DUAL_MODE0 8
`define LAT_DUAL_MODE1 4
`define LAT_SINGLE_A 8
`define LAT_SINGLE_B 9
`define LAT_MAX 9
`endif

// File: verilog/adc_timing_pkg.sv
package adc_timing_pkg;
  // operating options chosen by clock mode and single bus bits
  typedef enum logic [1:0] {
    opt_dual_80,
    opt_dual_40,
    opt_single_latch40,
    opt_single_latch80
  } option_type;
  typedef enum {
    st_run,
    st_standby
  } power_state_type;
endpackage : adc_timing_pkg

// File: verilog/level_sync.sv
`timescale 1ns/1ps
// two flop synchroniser for a level crossing into the clk domain (link clock for control, pclk for status)
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // first stage feeds only the second stage
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : level_sync

// File: verilog/latency_line.sv
`timescale 1ns/1ps
// delay line addressed by an index, tap chosen per sample
module latency_line #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  input wire logic [3:0] tap,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [DEPTH];
  logic [WIDTH-1:0] next_stage [DEPTH];

  // shift every edge; tap 1 means the value pushed one edge ago
  always_comb begin
    next_stage[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      next_stage[i] = stage[i-1];
    end
    if (tap == 4'h0 || int'(tap) > DEPTH) begin
      dout = stage[0];
    end else begin
      dout = stage[int'(tap) - 1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end
endmodule : latency_line

// File: verilog/adc_timing_top.sv
`timescale 1ns/1ps
`include "adc_timing_params.svh"
// converter digital timing: apb control on pclk, sample path on the input clock
module adc_timing_top
  import adc_timing_pkg::*;
#(
  parameter int DATA_WIDTH = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_clk,
  input wire logic [DATA_WIDTH-1:0] raw_sample_a,
  input wire logic [DATA_WIDTH-1:0] raw_sample_b,
  output logic [DATA_WIDTH-1:0] primary_output_word,
  output logic primary_output_oe,
  output logic [DATA_WIDTH-1:0] secondary_output_word,
  output logic secondary_output_oe,
  output logic output_latch_clock,
  output logic output_latch_clock_n,
  output logic latch_clock_oe,
  output logic internal_sample_clock,
  output logic reference_enable,
  output logic converter_powered
);
  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [5:0] ctrl;
  logic [5:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [2:0] status_sync;
  logic setup_phase;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // zero wait state slave; the answer is registered on the setup edge
  assign setup_phase = psel && !penable;
  always_comb begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && pwrite && addr_hit(paddr, `CTRL_OFFSET)) begin
      next_ctrl = pwdata[5:0];
    end
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      if (addr_hit(paddr, `CTRL_OFFSET)) begin
        next_prdata = {26'h0, ctrl};
      end else if (addr_hit(paddr, `STATUS_OFFSET)) begin
        next_prdata = {29'h0, status_sync};
      end else begin
        next_pslverr = 1'b1; // unmapped address
      end
    end else if (psel && penable) begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET_VALUE;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= setup_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossing: control bits into the conversion domain, status back
  logic conv_rst_n_meta;
  logic conv_rst_n;
  logic [5:0] cfg;
  logic [5:0] cfg_flipped;
  logic [2:0] status_conv;

  // reset release is synchronised so the conversion domain leaves reset cleanly
  always_ff @(posedge conv_clk or negedge presetn) begin
    if (!presetn) begin
      conv_rst_n_meta <= 1'b0;
      conv_rst_n <= 1'b0;
    end else begin
      conv_rst_n_meta <= 1'b1;
      conv_rst_n <= conv_rst_n_meta;
    end
  end

  // bits are quasi static; a two edge skew between bits is tolerated
  // the synchroniser clears to zero, so the reset value is folded out across it;
  // otherwise the buses would drive for a few edges after every reset
  level_sync #(.WIDTH(6)) ctrl_sync (
    .clk(conv_clk),
    .rst_n(conv_rst_n),
    .async_in(ctrl ^ `CTRL_RESET_VALUE),
    .sync_out(cfg_flipped)
  );
  assign cfg = cfg_flipped ^ `CTRL_RESET_VALUE;

  level_sync #(.WIDTH(3)) stat_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(status_conv),
    .sync_out(status_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // option decode and sample phase
  option_type option;
  power_state_type pstate;
  power_state_type next_pstate;
  logic phase;
  logic next_phase;
  logic sample_now;
  logic mode_bit;
  logic single_bit;

  assign mode_bit = cfg[`CTRL_CLOCK_MODE_BIT];
  assign single_bit = cfg[`CTRL_SINGLE_BUS_BIT];

  // mode and single bus bits select one of four options
  always_comb begin
    case ({single_bit, mode_bit})
      2'b00: option = opt_dual_80;
      2'b01: option = opt_dual_40;
      2'b10: option = opt_single_latch40;
      default: option = opt_single_latch80;
    endcase
  end

  // 40MHz clock samples each edge, 80MHz clock every other edge
  always_comb begin
    next_phase = phase;
    if (option == opt_dual_40) begin
      next_phase = 1'b1;
    end else begin
      next_phase = ~phase;
    end
    sample_now = (option == opt_dual_40) || phase;
  end

  // standby gates the sample path
  always_comb begin
    case (pstate)
      st_run: next_pstate = cfg[`CTRL_STANDBY_BIT] ? st_standby : st_run;
      st_standby: next_pstate = cfg[`CTRL_STANDBY_BIT] ? st_standby : st_run;
      default: next_pstate = st_run;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // latency lines per channel
  logic [DATA_WIDTH-1:0] held_a;
  logic [DATA_WIDTH-1:0] held_b;
  logic [DATA_WIDTH-1:0] next_held_a;
  logic [DATA_WIDTH-1:0] next_held_b;
  logic [DATA_WIDTH-1:0] late_a;
  logic [DATA_WIDTH-1:0] late_b;
  logic [3:0] tap_a;
  logic [3:0] tap_b;

  // hold the sampled word between sample edges (one sample per 40MHz period)
  always_comb begin
    next_held_a = held_a;
    next_held_b = held_b;
    if (sample_now && pstate == st_run) begin
      next_held_a = raw_sample_a;
      next_held_b = raw_sample_b;
    end
  end

  // held word loads on the sample edge; the line adds tap edges, the output flop one more
  always_comb begin
    if (single_bit) begin
      tap_a = 4'(`LAT_SINGLE_A - 1);
      tap_b = 4'(`LAT_SINGLE_B - 1);
    end else if (mode_bit) begin
      tap_a = 4'(`LAT_DUAL_MODE1 - 1);
      tap_b = 4'(`LAT_DUAL_MODE1 - 1);
    end else begin
      tap_a = 4'(`LAT_DUAL_MODE0 - 1);
      tap_b = 4'(`LAT_DUAL_MODE0 - 1);
    end
  end

  latency_line #(.WIDTH(DATA_WIDTH), .DEPTH(`LAT_MAX)) line_a (
    .clk(conv_clk),
    .rst_n(conv_rst_n),
    .din(held_a),
    .tap(tap_a),
    .dout(late_a)
  );

  latency_line #(.WIDTH(DATA_WIDTH), .DEPTH(`LAT_MAX)) line_b (
    .clk(conv_clk),
    .rst_n(conv_rst_n),
    .din(held_b),
    .tap(tap_b),
    .dout(late_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output stage
  logic [DATA_WIDTH-1:0] next_primary;
  logic [DATA_WIDTH-1:0] next_secondary;
  logic next_primary_oe;
  logic next_secondary_oe;
  logic next_latch_clk;
  logic next_latch_oe;
  logic drive;

  function automatic logic [DATA_WIDTH-1:0] fmt(input logic [DATA_WIDTH-1:0] w, input logic signed_sel);
    fmt = signed_sel ? {~w[DATA_WIDTH-1], w[DATA_WIDTH-2:0]} : w;
  endfunction : fmt

  // outputs float while disabled or powered down
  assign drive = !cfg[`CTRL_OUT_ENABLE_N_BIT] && pstate == st_run;

  always_comb begin
    next_primary_oe = drive;
    next_secondary_oe = drive && !single_bit;
    next_latch_oe = drive;
    next_primary = fmt(late_a, cfg[`CTRL_SIGNED_BIT]);
    next_secondary = fmt(late_b, cfg[`CTRL_SIGNED_BIT]);
    next_latch_clk = phase;
    if (single_bit) begin
      // interleave: a on one half of the 40MHz period, b on the other
      next_primary = phase ? fmt(late_b, cfg[`CTRL_SIGNED_BIT]) : fmt(late_a, cfg[`CTRL_SIGNED_BIT]);
      next_secondary = '0;
      next_latch_clk = (option == opt_single_latch80) ? ~output_latch_clock : phase;
    end else if (option == opt_dual_40) begin
      next_latch_clk = ~output_latch_clock;
    end
  end

  always_ff @(posedge conv_clk or negedge conv_rst_n) begin
    if (!conv_rst_n) begin
      phase <= 1'b0;
      pstate <= st_run;
      held_a <= '0;
      held_b <= '0;
      primary_output_word <= '0;
      secondary_output_word <= '0;
      primary_output_oe <= 1'b0;
      secondary_output_oe <= 1'b0;
      output_latch_clock <= 1'b0;
      output_latch_clock_n <= 1'b1;
      latch_clock_oe <= 1'b0;
      internal_sample_clock <= 1'b0;
      reference_enable <= 1'b1;
      converter_powered <= 1'b1;
      status_conv <= 3'h0;
    end else begin
      phase <= next_phase;
      pstate <= next_pstate;
      held_a <= next_held_a;
      held_b <= next_held_b;
      primary_output_word <= next_primary;
      secondary_output_word <= next_secondary;
      primary_output_oe <= next_primary_oe;
      secondary_output_oe <= next_secondary_oe;
      output_latch_clock <= next_latch_clk;
      output_latch_clock_n <= ~next_latch_clk;
      latch_clock_oe <= next_latch_oe;
      internal_sample_clock <= sample_now;
      reference_enable <= !cfg[`CTRL_REF_PDWN_BIT];
      converter_powered <= (next_pstate == st_run);
      status_conv <= {!cfg[`CTRL_REF_PDWN_BIT], next_pstate == st_standby, phase};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  standby_float_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    pstate == st_standby |=> !primary_output_oe && !secondary_output_oe)
    else $error("outputs driven in standby");
  oe_drive_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    (!cfg[`CTRL_OUT_ENABLE_N_BIT] && pstate == st_run) |=> primary_output_oe)
    else $error("outputs not driven when enabled");
  single_float_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    single_bit |=> !secondary_output_oe)
    else $error("secondary bus driven in single bus mode");
  ref_pdwn_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    cfg[`CTRL_REF_PDWN_BIT] && !cfg[`CTRL_STANDBY_BIT] && pstate == st_run |=> !reference_enable && converter_powered)
    else $error("reference powerdown wrong");
  half_rate_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    (option != opt_dual_40) && $stable(option) && sample_now |=> !sample_now || option == opt_dual_40)
    else $error("80MHz mode sampled on adjacent edges");
  full_rate_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    option == opt_dual_40 |-> sample_now)
    else $error("40MHz mode missed a sample");
  dual_lat_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    (!single_bit && mode_bit) [*8] |-> primary_output_word == fmt($past(held_a, 4), cfg[`CTRL_SIGNED_BIT]))
    else $error("dual bus mode 1 latency wrong");
  single_lat_a: assert property (@(posedge conv_clk) disable iff (!conv_rst_n)
    single_bit [*8] ##1 single_bit && !phase |=> primary_output_word == fmt($past(held_a, 8), cfg[`CTRL_SIGNED_BIT]))
    else $error("single bus channel a latency wrong");
  apb_write_c: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pwrite);
  single_mode_c: cover property (@(posedge conv_clk) disable iff (!conv_rst_n) option == opt_single_latch80);
  standby_c: cover property (@(posedge conv_clk) disable iff (!conv_rst_n) pstate == st_standby);
endmodule : adc_timing_top

// File: sim/capture_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side capture logic: resolves the floating buses and counts latched words
module capture_model (
  input wire logic clk,
  input wire logic latch_clk,
  input wire logic latch_oe,
  input wire logic oe_a,
  input wire logic oe_b,
  input wire logic [9:0] word_a,
  input wire logic [9:0] word_b,
  output logic [9:0] bus_a,
  output logic [9:0] bus_b,
  output int n_caps
);
  logic [9:0] last_a = 10'h000;
  logic [9:0] last_b = 10'h000;
  // a released bus shows the inverse of its last value, never a stale copy
  assign bus_a = oe_a ? word_a : ~last_a;
  assign bus_b = oe_b ? word_b : ~last_b;
  // remember the last driven values
  always @(posedge clk) begin
    if (oe_a) last_a <= word_a;
    if (oe_b) last_b <= word_b;
  end
  // words are only latched while the latch clock is driven
  initial n_caps = 0;
  always @(posedge latch_clk) begin
    if (latch_oe === 1'b1) n_caps <= n_caps + 1;
  end
endmodule : capture_model

// File: sim/dual_adc_clock_and_output_timing_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dual_adc_clock_and_output_timing_bench;
  import adc_timing_pkg::*;
  typedef struct {logic [31:0] ctrl; int la; int lb; int ns; logic sec;} row_type;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_clk = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, poe, soe, lclk, lclk_n, loe, isc, ref_en, pwr;
  logic [9:0] raw_sample_a = 10'h000, raw_sample_b = 10'h155, pw, sw, bus_a, bus_b;
  logic [9:0] ha [0:15], hb [0:15], f;
  int n_fail = 0, total_checks = 0, n_caps, ns, c0;
  logic m;
  row_type rows [5] = '{'{32'h00, 8, 8, 4, 1}, '{32'h01, 4, 4, 8, 1}, '{32'h02, 8, 9, 4, 0},
    '{32'h07, 8, 9, 4, 0}, '{32'h04, 8, 8, 4, 1}};
  // link clock offset so its edges drift against pclk
  always #20 pclk = ~pclk;
  initial #7 forever #32 conv_clk = ~conv_clk;
  adc_timing_top adc_timing_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_clk(conv_clk), .raw_sample_a(raw_sample_a), .raw_sample_b(raw_sample_b),
    .primary_output_word(pw), .primary_output_oe(poe), .secondary_output_word(sw),
    .secondary_output_oe(soe), .output_latch_clock(lclk), .output_latch_clock_n(lclk_n),
    .latch_clock_oe(loe), .internal_sample_clock(isc), .reference_enable(ref_en), .converter_powered(pwr));
  capture_model capture_model_inst (.clk(conv_clk), .latch_clk(lclk), .latch_oe(loe), .oe_a(poe),
    .oe_b(soe), .word_a(pw), .word_b(sw), .bus_a(bus_a), .bus_b(bus_b), .n_caps(n_caps));
  // history of the input words presented at each link edge, sampled or not, newest first
  always @(posedge conv_clk) begin
    for (int i = 15; i > 0; i--) begin
      ha[i] = ha[i-1];
      hb[i] = hb[i-1];
    end
    ha[0] = raw_sample_a;
    hb[0] = raw_sample_b;
    raw_sample_a <= raw_sample_a + 10'h001;
    raw_sample_b <= raw_sample_b + 10'h025;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge
  // host side paces configuration writes one transfer at a time
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) chk(0, 1, "no pready");
  endtask : apb
  task complete_run;
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  function logic hit(logic [9:0] w, logic [9:0] h [0:15], int l, logic [9:0] fm);
    return w === (h[l] ^ fm) || w === (h[l+1] ^ fm);
  endfunction : hit
  // watchdog sized well past the whole sequence
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    chk({31'h0, poe}, 0, "oe at reset");
    apb(0, 12'h000, 0);
    chk(q, 32'h20, "ctrl reset");
    apb(0, 12'h008, 0);
    chk({31'h0, err}, 1, "unmapped");
    // status needs the conversion domain out of reset and two pclk edges back
    apb(0, 12'h004, 0);
    chk(q[2], 1, "ref on");
    // option table: latency, bus use, sample rate and format per setting
    foreach (rows[r]) begin
      apb(1, 12'h000, rows[r].ctrl);
      repeat (14) @(posedge conv_clk);
      f = rows[r].ctrl[2] ? 10'h200 : 10'h000;
      ns = 0;
      for (int k = 0; k < 8; k++) begin
        @(negedge conv_clk);
        ns += isc;
        m = hit(bus_a, ha, rows[r].la, f) || (!rows[r].sec && hit(bus_a, hb, rows[r].lb, f));
        chk({31'h0, m}, 1, "primary word");
        chk({31'h0, soe}, {31'h0, rows[r].sec}, "secondary oe");
        chk({31'h0, lclk_n}, {31'h0, ~lclk}, "latch clock pair");
        if (rows[r].sec) chk({31'h0, hit(bus_b, hb, rows[r].la, f)}, 1, "secondary word");
      end
      chk(ns, rows[r].ns, "sample edges");
    end
    // reference powerdown keeps converting and latching
    apb(1, 12'h000, 32'h10);
    repeat (6) @(negedge conv_clk);
    c0 = n_caps;
    repeat (4) @(negedge conv_clk);
    chk({30'h0, ref_en, pwr}, 32'h1, "ref pdwn");
    chk({31'h0, n_caps > c0}, 1, "captures run");
    // standby floats everything
    apb(1, 12'h000, 32'h08);
    repeat (6) @(negedge conv_clk);
    chk({29'h0, pwr, poe, soe}, 32'h0, "standby");
    chk({31'h0, loe}, 0, "latch clock off");
    // output enable released floats the buses
    apb(1, 12'h000, 32'h20);
    repeat (6) @(negedge conv_clk);
    chk({30'h0, poe, soe}, 32'h0, "oe released");
    apb(1, 12'h000, 32'h00);
    repeat (6) @(negedge conv_clk);
    chk({31'h0, poe}, 1, "oe again");
    // reset in mid run returns control to its floating default
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk({29'h0, poe, ref_en, pwr}, 32'h3, "oe in reset");
    presetn <= 1;
    repeat (6) @(negedge conv_clk);
    chk({31'h0, poe}, 0, "oe after reset");
    apb(0, 12'h000, 0);
    chk(q, 32'h20, "ctrl after reset");
    complete_run();
  end
endmodule : dual_adc_clock_and_output_timing_bench
